/* design/psl_params.svh */
// Register offsets, field positions, reset values and timing counts for the lamp block.
`ifndef PSL_PARAMS_SVH
`define PSL_PARAMS_SVH
// ==========================================================================
// Register word indices; the byte address is four times the index.
`define PSL_IDX_STATUS      8'h17
`define PSL_IDX_SOURCE      8'h18
`define PSL_IDX_POLFORCE    8'h19
`define PSL_IDX_BLINK       8'h1a
`define PSL_IDX_IRQ_STATUS  8'h1b
`define PSL_IDX_IRQ_MASK    8'h1c
// ==========================================================================
// Reset values.
`define PSL_RST_SOURCE      16'h6150
`define PSL_RST_POLFORCE    16'h4444
`define PSL_RST_BLINK       2'h2
// ==========================================================================
// Status word bit positions.
`define PSL_ST_PD_FOUND     15
`define PSL_ST_PD_NOSIG     14
`define PSL_ST_PD_TIMEOUT   13
`define PSL_ST_PD_OTHER     12
`define PSL_ST_PAT_LOCK     11
`define PSL_ST_PAT_LOST     10
`define PSL_ST_GEN_ACTIVE   9
`define PSL_ST_LEG_MASTER   8
`define PSL_ST_LEG_SLAVE    7
`define PSL_ST_CORE_AWAKE   6
// ==========================================================================
// Polarity and force bit offsets inside each 4-bit lamp nibble.
`define PSL_PF_FORCE_ON     0
`define PSL_PF_FORCE_VAL    1
`define PSL_PF_ACT_HIGH     2
`define PSL_POL_MASK        16'h7777
// ==========================================================================
// Blink half periods in milliseconds and the clock rate.
`define PSL_CLK_HZ          200000000
`define PSL_BLINK_MS_0      50
`define PSL_BLINK_MS_1      100
`define PSL_BLINK_MS_2      200
`define PSL_BLINK_MS_3      500
`endif

/* design/psl_pkg.sv */
// Types shared by the lamp status and control block.
package psl_pkg;
  // Lamp source codes.
  typedef enum logic [3:0] {
    PSL_SRC_LINK      = 4'h0,
    PSL_SRC_ACT       = 4'h1,
    PSL_SRC_TX        = 4'h2,
    PSL_SRC_RX        = 4'h3,
    PSL_SRC_COL       = 4'h4,
    PSL_SRC_L1000     = 4'h5,
    PSL_SRC_L100      = 4'h6,
    PSL_SRC_L10       = 4'h7,
    PSL_SRC_L10_100   = 4'h8,
    PSL_SRC_L100_1000 = 4'h9,
    PSL_SRC_FDX       = 4'ha,
    PSL_SRC_LINK_BLK  = 4'hb,
    PSL_SRC_NONE      = 4'hc,
    PSL_SRC_TXRX_ERR  = 4'hd,
    PSL_SRC_RX_ERR    = 4'he,
    PSL_SRC_RSVD      = 4'hf
  } psl_src_t;
  // Link conditions from the datapaths.
  typedef struct packed {
    logic link_good;
    logic tx_act;
    logic rx_act;
    logic collision;
    logic up_1000;
    logic up_100;
    logic up_10;
    logic full_duplex;
    logic tx_err;
    logic rx_err;
  } psl_link_t;
  // Status conditions; events are one-cycle pulses, the rest levels.
  typedef struct packed {
    logic powered_dev_found;
    logic powered_dev_no_signal;
    logic powered_dev_timeout;
    logic powered_dev_absent_other;
    logic pattern_checker_locked;
    logic pattern_checker_lost;
    logic traffic_gen_active;
    logic legacy_code_master;
    logic legacy_code_slave;
    logic core_awake;
  } psl_stat_t;
endpackage

/* design/psl_lamp_ctrl.sv */
// PHY status word and four-lamp source, polarity and force control.
// Function
// R01 - Bit 15 sets on powered device, read clears
// R02 - Bit 14 sets on no signal, read clears
// R03 - Bit 13 sets on watchdog expiry, read clears
// R04 - Bit 12 sets on non-powered partner, read clears
// R05 - Bit 11 shows pattern checker lock live
// R06 - Bit 10 latches lock loss, read clears
// R07 - Bit 9 shows traffic generator active
// R08 - Bit 8 shows master legacy scrambler mode
// R09 - Bit 7 shows slave legacy scrambler mode
// R10 - Bit 6 shows core awake, resets one
// R11 - Four-bit code selects each lamp source
// R12 - Four source fields, word resets 0x6150
// R13 - Per-lamp polarity bit, strap sets reset
// R14 - Bit 12 forces aux lamp to bit 13
// R15 - Bit 8 forces lamp 2 to bit 9
// R16 - Bit 4 forces lamp 1 to bit 5
// R17 - Bit 0 forces lamp 0 to bit 1
// R18 - Blink period 50/100/200/500 ms, default 200
// R19 - Polarity applied after selection and forcing
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "psl_params.svh"
module psl_lamp_ctrl #(
  parameter int CLK_HZ = `PSL_CLK_HZ
) (
  input  wire logic              clk_sys,     // System clock.
  input  wire logic              reset_n,     // Asynchronous active-low reset.
  input  wire logic              clk_en,      // Freezes all state but the reset synchroniser while low.
  input  wire logic              wb_cyc_i,    // Wishbone cycle.
  input  wire logic              wb_stb_i,    // Wishbone strobe.
  input  wire logic              wb_we_i,     // Wishbone write enable.
  input  wire logic [7:0]        wb_adr_i,    // Wishbone byte address.
  input  wire logic [3:0]        wb_sel_i,    // Wishbone byte selects.
  input  wire logic [31:0]       wb_dat_i,    // Wishbone write data.
  output logic      [31:0]       wb_dat_o,    // Wishbone read data.
  output logic                   wb_ack_o,    // Wishbone acknowledge.
  input  wire psl_pkg::psl_stat_t stat_i,     // Status conditions.
  input  wire psl_pkg::psl_link_t link_i,     // Link conditions.
  input  wire logic [3:0]        strap_pol,   // Polarity straps, lamp 3 is aux.
  input  wire logic              strap_valid, // Straps apply when high.
  output logic      [3:0]        lamp_o,      // Lamp pins, bit 3 is aux lamp.
  output logic                   irq_o        // Level interrupt.
);
  // ==========================================================================
  // Elaboration checks and blink counts.
  localparam int BLK0 = CLK_HZ / 1000 * `PSL_BLINK_MS_0;
  localparam int BLK1 = CLK_HZ / 1000 * `PSL_BLINK_MS_1;
  localparam int BLK2 = CLK_HZ / 1000 * `PSL_BLINK_MS_2;
  localparam int BLK3 = CLK_HZ / 1000 * `PSL_BLINK_MS_3;
  // The blink counter is 28 bits wide, so the slowest period must fit in it,
  // and the millisecond scaling needs at least one cycle per millisecond.
  if (CLK_HZ < 1000) begin : g_clk_slow
    $error("psl_lamp_ctrl: CLK_HZ below 1000");
  end
  if (BLK3 >= 2**28) begin : g_clk_fast
    $error("psl_lamp_ctrl: CLK_HZ too high for the blink counter");
  end

  // ==========================================================================
  // Reset synchroniser.
  // The pin reset enters at once but leaves through two flops, so every
  // register below comes out of reset on one clean edge even when the pin
  // is released close to the clock.
  logic rst_s1_r;
  logic rst_s2_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_s2_r;

  // ==========================================================================
  // Register state.
  logic [15:0] src_r, src_nxt;
  logic [15:0] pf_r, pf_nxt;
  logic [1:0]  blink_r, blink_nxt;
  logic [5:0]  sticky_r, sticky_nxt;
  logic [5:0]  irq_st_r, irq_st_nxt;
  logic [5:0]  irq_mk_r, irq_mk_nxt;
  logic        strap_done_r, strap_done_nxt;
  logic        ack_nxt;
  logic [31:0] rdat_nxt;
  logic [27:0] bcnt_r, bcnt_nxt;
  logic        bph_r, bph_nxt;
  logic [3:0]  lamp_nxt;
  logic        irq_nxt;

  // Request decode: a new access is taken when no acknowledge is pending.
  // Gating on the pending acknowledge keeps a master that holds its strobe
  // through the acknowledge cycle from being taken twice; a second status
  // read would otherwise clear flags that nobody has seen.
  logic        req;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  logic [15:0] wmask;
  logic [5:0]  events;
  logic [15:0] status_word;
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i;
  assign rd    = req && !wb_we_i;
  assign idx   = wb_adr_i[7:2];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Event pulses in sticky order: found, nosig, timeout, other, lost.
  // Bit 0 of the sticky and interrupt vectors is spare and stays zero.
  // An event that lasts several cycles simply sets its flag again each cycle.
  assign events = {stat_i.powered_dev_found, stat_i.powered_dev_no_signal,
                   stat_i.powered_dev_timeout, stat_i.powered_dev_absent_other,
                   stat_i.pattern_checker_lost, 1'b0};

  // Live status word assembled from sticky flags and live levels.
  // Bits 5 to 0 are reserved and read zero; the live levels are not
  // latched, so a read shows them as they stand in the cycle of the request.
  always_comb begin
    status_word = 16'h0000;
    status_word[`PSL_ST_PD_FOUND]   = sticky_r[5];                    // see R01
    status_word[`PSL_ST_PD_NOSIG]   = sticky_r[4];                    // see R02
    status_word[`PSL_ST_PD_TIMEOUT] = sticky_r[3];                    // see R03
    status_word[`PSL_ST_PD_OTHER]   = sticky_r[2];                    // see R04
    status_word[`PSL_ST_PAT_LOCK]   = stat_i.pattern_checker_locked;  // see R05
    status_word[`PSL_ST_PAT_LOST]   = sticky_r[1];                    // see R06
    status_word[`PSL_ST_GEN_ACTIVE] = stat_i.traffic_gen_active;      // see R07
    status_word[`PSL_ST_LEG_MASTER] = stat_i.legacy_code_master;      // see R08
    status_word[`PSL_ST_LEG_SLAVE]  = stat_i.legacy_code_slave;       // see R09
    status_word[`PSL_ST_CORE_AWAKE] = stat_i.core_awake;              // see R10
  end

  // Next values of the register file and the bus answer.
  // The read word is prepared every cycle for the addressed register and
  // captured with the acknowledge; besides events and the strap capture, only a taken request changes state.
  // Unmapped indices answer with zero and ignore writes, and the status
  // word is read-only, so a write there is dropped without an error.
  always_comb begin
    src_nxt        = src_r;
    pf_nxt         = pf_r;
    blink_nxt      = blink_r;
    irq_mk_nxt     = irq_mk_r;
    strap_done_nxt = 1'b1;
    ack_nxt        = req;
    rdat_nxt       = 32'h0000_0000;
    sticky_nxt     = sticky_r;
    irq_st_nxt     = irq_st_r;
    // Polarity straps are caught once after reset release.
    // A write to the polarity word in that same cycle overrides the straps.
    if (!strap_done_r && strap_valid) begin
      pf_nxt[14] = strap_pol[3];                                      // see R13
      pf_nxt[10] = strap_pol[2];                                      // see R13
      pf_nxt[6]  = strap_pol[1];                                      // see R13
      pf_nxt[2]  = strap_pol[0];                                      // see R13
    end
    if (idx == `PSL_IDX_STATUS) begin
      rdat_nxt = {16'h0000, status_word};
      if (rd) begin
        sticky_nxt = 6'h00;                                  // see R01 R02 R03 R04 R06
      end
    end else if (idx == `PSL_IDX_SOURCE) begin
      rdat_nxt = {16'h0000, src_r};
      if (wr) begin
        src_nxt = (src_r & ~wmask) | (wb_dat_i[15:0] & wmask);        // see R12
      end
    end else if (idx == `PSL_IDX_POLFORCE) begin
      rdat_nxt = {16'h0000, pf_r};
      if (wr) begin
        pf_nxt = (pf_r & ~(wmask & `PSL_POL_MASK))
                 | (wb_dat_i[15:0] & wmask & `PSL_POL_MASK);
      end
    end else if (idx == `PSL_IDX_BLINK) begin
      rdat_nxt = {30'h0000_0000, blink_r};
      if (wr && wb_sel_i[0]) begin
        blink_nxt = wb_dat_i[1:0];                                    // see R18
      end
    end else if (idx == `PSL_IDX_IRQ_STATUS) begin
      // Same layout as the status word: bits 15 to 12 and bit 10.
      rdat_nxt = {16'h0000, irq_st_r[5:2], 1'b0, irq_st_r[1], 10'h000};
      if (wr && wb_sel_i[1]) begin
        irq_st_nxt = irq_st_r & ~{wb_dat_i[15:12], wb_dat_i[10], 1'b0};
      end
    end else if (idx == `PSL_IDX_IRQ_MASK) begin
      // Same layout as the status word: bits 15 to 12 and bit 10.
      rdat_nxt = {16'h0000, irq_mk_r[5:2], 1'b0, irq_mk_r[1], 10'h000};
      if (wr && wb_sel_i[1]) begin
        irq_mk_nxt = {wb_dat_i[15:12], wb_dat_i[10], 1'b0};
      end
    end
    // Hardware events win over any clear in the same cycle.
    sticky_nxt = sticky_nxt | events;                        // see R01 R02 R03 R04 R06
    irq_st_nxt = irq_st_nxt | events;
  end

  // Register file and bus answer.
  // A low clock enable freezes every register, the acknowledge included.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_r        <= `PSL_RST_SOURCE;                                // see R12
      pf_r         <= `PSL_RST_POLFORCE;                              // see R13
      blink_r      <= `PSL_RST_BLINK;                                 // see R18
      sticky_r     <= 6'h00;
      irq_st_r     <= 6'h00;
      irq_mk_r     <= 6'h00;
      strap_done_r <= 1'b0;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end else if (clk_en) begin
      src_r        <= src_nxt;
      pf_r         <= pf_nxt;
      blink_r      <= blink_nxt;
      sticky_r     <= sticky_nxt;
      irq_st_r     <= irq_st_nxt;
      irq_mk_r     <= irq_mk_nxt;
      strap_done_r <= strap_done_nxt;
      wb_ack_o     <= ack_nxt;
      wb_dat_o     <= rdat_nxt;
    end
  end

  // ==========================================================================
  // Blink timer: the phase toggles once every selected period.
  // A shorter period selected while the count is past its new end toggles
  // the phase on the next edge and starts over, so no stale count lingers.
  // Lowering CLK_HZ shortens every period in proportion for simulation.
  logic [27:0] blink_max;
  always_comb begin
    case (blink_r)
      2'h0:    blink_max = 28'(BLK0 - 1);                              // see R18
      2'h1:    blink_max = 28'(BLK1 - 1);                              // see R18
      2'h2:    blink_max = 28'(BLK2 - 1);                              // see R18
      default: blink_max = 28'(BLK3 - 1);                              // see R18
    endcase
    bcnt_nxt = bcnt_r + 28'h000_0001;
    bph_nxt  = bph_r;
    if (bcnt_r >= blink_max) begin
      bcnt_nxt = 28'h000_0000;
      bph_nxt  = !bph_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_r <= 28'h000_0000;
      bph_r  <= 1'b0;
    end else if (clk_en) begin
      bcnt_r <= bcnt_nxt;
      bph_r  <= bph_nxt;
    end
  end

  // ==========================================================================
  // Lamp source selection, forcing and polarity.
  function automatic logic pick(input logic [3:0] code, input psl_pkg::psl_link_t l,
                                input logic ph);
    logic v;
    v = 1'b0;
    case (psl_pkg::psl_src_t'(code))
      psl_pkg::PSL_SRC_LINK:      v = l.link_good;                    // see R11
      psl_pkg::PSL_SRC_ACT:       v = l.tx_act | l.rx_act;
      psl_pkg::PSL_SRC_TX:        v = l.tx_act;
      psl_pkg::PSL_SRC_RX:        v = l.rx_act;
      psl_pkg::PSL_SRC_COL:       v = l.collision;
      psl_pkg::PSL_SRC_L1000:     v = l.link_good & l.up_1000;
      psl_pkg::PSL_SRC_L100:      v = l.link_good & l.up_100;
      psl_pkg::PSL_SRC_L10:       v = l.link_good & l.up_10;
      psl_pkg::PSL_SRC_L10_100:   v = l.link_good & (l.up_10 | l.up_100);
      psl_pkg::PSL_SRC_L100_1000: v = l.link_good & (l.up_100 | l.up_1000);
      psl_pkg::PSL_SRC_FDX:       v = l.full_duplex;
      psl_pkg::PSL_SRC_LINK_BLK:  v = l.link_good & !((l.tx_act | l.rx_act) & ph);
      psl_pkg::PSL_SRC_TXRX_ERR:  v = l.tx_err | l.rx_err;
      psl_pkg::PSL_SRC_RX_ERR:    v = l.rx_err;
      default:                    v = 1'b0;
    endcase
    return v;
  endfunction

  // Each lamp nibble of the polarity word sits at the lamp index times four.
  // Forcing replaces the logical on value and polarity is applied last, so a
  // forced one lights the lamp whatever level the lamp is wired for.
  // Lamp 3 is the auxiliary lamp, matching the top nibble of both words.
  always_comb begin
    lamp_nxt = 4'h0;
    for (int i = 0; i < 4; i++) begin
      logic on;
      on = pick(src_r[4*i +: 4], link_i, bph_r);                      // see R11 R12
      if (pf_r[4*i + `PSL_PF_FORCE_ON]) begin
        on = pf_r[4*i + `PSL_PF_FORCE_VAL];                           // see R14 R15 R16 R17
      end
      lamp_nxt[i] = pf_r[4*i + `PSL_PF_ACT_HIGH] ? on : !on;          // see R13 R19
    end
    irq_nxt = |(irq_st_r & irq_mk_r);
  end

  // Lamp pins and interrupt come straight from flip-flops.
  // Registering both keeps decode glitches off the pins and off the
  // interrupt line, at the cost of one cycle of delay.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lamp_o <= 4'h0;
      irq_o  <= 1'b0;
    end else if (clk_en) begin
      lamp_o <= lamp_nxt;
      irq_o  <= irq_nxt;
    end
  end
endmodule // psl_lamp_ctrl

/* verification/psl_lamp_panel.sv */
// Model of the four indicator lamps hung on the lamp pins.
`timescale 1ns/1ps
module psl_lamp_panel (
  input  wire logic [3:0] lamp_pin,   // Pins from the block, bit 3 is aux.
  input  wire logic [3:0] wired_high, // Lamps wired to glow on a high pin.
  output logic      [3:0] lit         // Lamps that glow.
);
  // A lamp glows when its pin sits at the level it is wired for.
  assign lit = lamp_pin ~^ wired_high;
endmodule // psl_lamp_panel

/* verification/psl_lamp_ctrl_assertions.sv */
// Checker for the bus answer and the lamp pins of the lamp block.
`timescale 1ns/1ps
`include "psl_params.svh"
module psl_lamp_ctrl_assertions (
  input wire logic               clk_sys,  // Clock.
  input wire logic               reset_n,  // Reset, active low.
  input wire logic               wb_cyc_i, // Cycle.
  input wire logic               wb_stb_i, // Strobe.
  input wire logic               wb_we_i,  // Write enable.
  input wire logic [7:0]         wb_adr_i, // Byte address.
  input wire logic [3:0]         wb_sel_i, // Byte selects.
  input wire logic [31:0]        wb_dat_i, // Write data.
  input wire logic [31:0]        wb_dat_o, // Read data.
  input wire logic               wb_ack_o, // Acknowledge.
  input wire psl_pkg::psl_link_t link_i,   // Link conditions.
  input wire logic [3:0]         lamp_o    // Lamp pins.
);
  logic [15:0] pf_r, pf_nxt, src_r, src_nxt, wm;
  logic        known_r, known_nxt, wr;
  logic [7:0]  idx;
  logic [3:0]  fexp;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadow copies of the lamp registers, followed from accepted writes.
  always_comb begin
    wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    idx = {2'h0, wb_adr_i[7:2]};
    wm = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    pf_nxt = pf_r;
    src_nxt = src_r;
    known_nxt = known_r;
    if (wr && idx == `PSL_IDX_POLFORCE) begin
      pf_nxt = ((wb_dat_i[15:0] & wm) | (pf_r & ~wm)) & `PSL_POL_MASK;
      known_nxt = 1'b1;
    end
    if (wr && idx == `PSL_IDX_SOURCE) begin
      src_nxt = (wb_dat_i[15:0] & wm) | (src_r & ~wm);
    end
  end
  // Straps may change the polarity reset value, so only written values count.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pf_r <= 16'h0000;
      src_r <= `PSL_RST_SOURCE;
      known_r <= 1'b0;
    end else begin
      pf_r <= pf_nxt;
      src_r <= src_nxt;
      known_r <= known_nxt;
    end
  end
  // Forced pin level: the forced value shown at the lamp's active level.
  assign fexp = {pf_r[13] ~^ pf_r[14], pf_r[9] ~^ pf_r[10],
                 pf_r[5] ~^ pf_r[6], pf_r[1] ~^ pf_r[2]};
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_force(int n);
    known_r && $stable(pf_r) && pf_r[4*n] |-> lamp_o[n] == fexp[n];
  endproperty
  chk_ack_taken: assert property (s_take |=> s_ack_pulse)
    else $error("ack did not pulse after a taken request");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_force_aux: assert property (p_force(3))
    else $error("aux lamp not at forced level");
  chk_force_lamp2: assert property (p_force(2))
    else $error("lamp 2 not at forced level");
  chk_force_lamp1: assert property (p_force(1))
    else $error("lamp 1 not at forced level");
  chk_force_lamp0: assert property (p_force(0))
    else $error("lamp 0 not at forced level");
  chk_link_lamp0: assert property (known_r && $stable(pf_r) && $stable(src_r)
    && !pf_r[0] && src_r[3:0] == 4'h0 |-> lamp_o[0] == ($past(link_i.link_good) ~^ pf_r[2]))
    else $error("lamp 0 does not follow link good");
endmodule // psl_lamp_ctrl_assertions
bind psl_lamp_ctrl psl_lamp_ctrl_assertions chk_u (.clk_sys, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_i, .lamp_o);

/* verification/tb.sv */
// Self-checking bench for the lamp status and control block.
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic we; logic [7:0] idx; logic [15:0] d;} psl_row_t;
  logic               clk_sys, reset_n, cyc, stb, we, sv, irq, ack, en;
  logic [7:0]         adr;
  logic [31:0]        dw, dr;
  logic [3:0]         sp, lamp, lit, wired, sel;
  logic [15:0]        q;
  psl_pkg::psl_stat_t st;
  psl_pkg::psl_link_t lk;
  int                 err_count, n_checks, blk;
  int                 bits [5] = '{15, 14, 13, 12, 10};
  // Reads carry the expected word, writes the data written.
  psl_row_t rows [11] = '{
    '{1'b0, 8'h18, 16'h6150},
    '{1'b0, 8'h19, 16'h4444},
    '{1'b0, 8'h1a, 16'h0002},
    '{1'b0, 8'h17, 16'h0040},
    '{1'b0, 8'h1b, 16'h0000},
    '{1'b0, 8'h1c, 16'h0000},
    '{1'b1, 8'h17, 16'hffff},
    '{1'b0, 8'h17, 16'h0040},
    '{1'b1, 8'h19, 16'hffff},
    '{1'b0, 8'h19, 16'h7777},
    '{1'b0, 8'h30, 16'h0000}};
  // A 20 kHz rate makes the 50 ms blink period last 1000 cycles.
  psl_lamp_ctrl #(.CLK_HZ(20000)) dut_u (.clk_sys, .reset_n, .clk_en(en), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .stat_i(st), .link_i(lk), .strap_pol(sp),
    .strap_valid(sv), .lamp_o(lamp), .irq_o(irq));
  psl_lamp_panel pan_u (.lamp_pin(lamp), .wired_high(wired), .lit(lit));
  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t register got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t pins got %b want %b", $time, got, exp);
    end
  endtask
  // One classic bus cycle, entered and left just after a rising edge.
  task automatic xfer(input logic w, input logic [7:0] i, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i[5:0], 2'b00};
    dw <= {16'h0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chk_pin({3'b000, ack}, 4'h1);
    q = dr[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] i, input logic [15:0] exp);
    xfer(1'b0, i, 16'h0000);
    chk_reg(q, exp);
  endtask
  task automatic pulse(input int b);
    st[b-6] <= 1'b1;
    @(posedge clk_sys);
    st[b-6] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Counts edges until lamp 0 changes, with a limit against a stuck lamp.
  task automatic wait_flip(output int n);
    logic s;
    n = 0;
    s = lamp[0];
    do begin
      @(posedge clk_sys);
      n++;
    end while (lamp[0] === s && n < 3000);
  endtask
  function automatic logic exp_src(input logic [3:0] c, input psl_pkg::psl_link_t l);
    case (c)
      4'h0, 4'hb: return l.link_good;
      4'h1: return l.tx_act | l.rx_act;
      4'h2: return l.tx_act;
      4'h3: return l.rx_act;
      4'h4: return l.collision;
      4'h5: return l.link_good & l.up_1000;
      4'h6: return l.link_good & l.up_100;
      4'h7: return l.link_good & l.up_10;
      4'h8: return l.link_good & (l.up_10 | l.up_100);
      4'h9: return l.link_good & (l.up_100 | l.up_1000);
      4'ha: return l.full_duplex;
      4'hd: return l.tx_err | l.rx_err;
      4'he: return l.rx_err;
      default: return 1'b0;
    endcase
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    #200000;
    err_count++;
    $display("FAIL t=%0t watchdog expired", $time);
    end_of_test();
  end
  // Main sequence: table of register cases, then hand-written cases.
  initial begin
    {reset_n, cyc, stb, we, sv, adr, dw, lk, err_count, n_checks} = '0;
    {sp, wired, st, sel, en} = {4'h5, 4'hf, 10'h001, 4'hf, 1'b1};
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    foreach (rows[i]) begin
      if (rows[i].we) xfer(1'b1, rows[i].idx, rows[i].d);
      else rd(rows[i].idx, rows[i].d);
    end
    $display("registers done");
    st <= 10'h02e;
    @(posedge clk_sys);
    rd(8'h17, 16'h0b80);
    st <= 10'h001;
    foreach (bits[k]) begin
      pulse(bits[k]);
      rd(8'h17, 16'h0040 | (16'h0001 << bits[k]));
      rd(8'h17, 16'h0040);
    end
    $display("status done");
    rd(8'h1b, 16'hf400);
    xfer(1'b1, 8'h1b, 16'h0400);
    rd(8'h1b, 16'hf000);
    xfer(1'b1, 8'h1b, 16'hffff);
    xfer(1'b1, 8'h1c, 16'h8000);
    pulse(14);
    chk_pin({3'b000, irq}, 4'h0);
    pulse(15);
    chk_pin({3'b000, irq}, 4'h1);
    rd(8'h1b, 16'hc000);
    xfer(1'b1, 8'h1b, 16'hffff);
    repeat (2) @(posedge clk_sys);
    chk_pin({3'b000, irq}, 4'h0);
    $display("interrupt done");
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, 8'h19, p ? 16'h0000 : 16'h4444);
      wired <= p ? 4'h0 : 4'hf;
      for (int c = 0; c < 32; c++) begin
        lk <= c[0] ? 10'h192 : 10'h26d;
        xfer(1'b1, 8'h18, {4{c[4:1]}});
        repeat (2) @(posedge clk_sys);
        chk_pin(lamp, {4{exp_src(c[4:1], lk) ^ p[0]}});
        chk_pin(lit, {4{exp_src(c[4:1], lk)}});
      end
    end
    xfer(1'b1, 8'h18, 16'hcccc);
    xfer(1'b1, 8'h19, 16'h3571);
    wired <= 4'h6;
    repeat (2) @(posedge clk_sys);
    chk_pin(lamp, 4'h3);
    chk_pin(lit, 4'ha);
    $display("lamps done");
    sel <= 4'h1;
    xfer(1'b1, 8'h18, 16'h0000);
    sel <= 4'hf;
    rd(8'h18, 16'hcc00);
    lk <= 10'h300;
    xfer(1'b1, 8'h19, 16'h4444);
    xfer(1'b1, 8'h18, 16'h000b);
    xfer(1'b1, 8'h1a, 16'h0000);
    wait_flip(blk);
    wait_flip(blk);
    chk_reg(16'(blk), 16'h03e8);
    $display("blink done");
    rd(8'h17, 16'hc040);
    en <= 1'b0;
    pulse(15);
    en <= 1'b1;
    rd(8'h17, 16'h0040);
    $display("enable done");
    sv <= 1'b1;
    lk <= 10'h000;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(8'h19, 16'h0404);
    chk_pin(lamp, 4'ha);
    $display("strap done");
    end_of_test();
  end
endmodule // tb
